// >>> gpio_pin_slice.sv
// pin driver, pullup gate, input sampler and read mux for one port
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_slice #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cen,
  // register state
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pue,
  // peripheral ownership
  input wire logic [W-1:0] own,
  input wire logic [W-1:0] own_out,
  input wire logic [W-1:0] own_drive,
  // pin side
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out_q,
  output logic [W-1:0] pin_oe_n_q,
  output logic [W-1:0] pullup_q,
  output logic [W-1:0] level_q,
  // value seen by a data register read
  output logic [W-1:0] rd_val
);
  // effective drive and value after peripheral takeover
  logic [W-1:0] drive;
  logic [W-1:0] value;

  // peripherals override direction on pins they own
  always_comb begin
    drive = (own & own_drive) | (~own & dir);
    value = (own & own_out) | (~own & latch);
  end

  // pins are synchronous; one sample register feeds reads
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= '0;
    end else if (cen) begin
      level_q <= pin_in;
    end
  end

  // registered drive; pullup only on a pin left undriven
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_oe_n_q <= '1;
      pin_out_q <= '0;
      pullup_q <= '0;
    end else if (cen) begin
      pin_oe_n_q <= ~drive;
      pin_out_q <= value;
      pullup_q <= pue & ~drive;
    end
  end

  // direction picks latch or pin even while a peripheral owns it
  assign rd_val = (dir & latch) | (~dir & level_q);
endmodule : gpio_pin_slice
`default_nettype wire

// >>> gpio_pin_world.sv
// partner model: external drivers, pullups and floating wires on one port
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_world #(
  parameter int W = 8
) (
  // clock
  input wire logic clock,
  // device side
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull_on,
  // external driver
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  // resolved pin level
  output logic [W-1:0] level
);
  // a released wire without pullup wanders, so stale values never pass
  logic [W-1:0] float_q = '0;
  // toggle the floating pattern every cycle
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end
  // device drive wins, then the outside driver, then the pullup
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level[i] = !oe_n[i] ? pin_out[i] : ext_en[i] ? ext[i] : pull_on[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : gpio_pin_world
`default_nettype wire

// >>> gpio_ports_c_d_e.sv
// general-purpose ports c, d and e behind an avalon-mm slave
// Functional notes
// [RULE1] port c direction: 1 output; reset clears
// [RULE2] port c read: latch if output, pin otherwise
// [RULE3] latch writes always accepted, input unaffected
// [RULE4] pullup only when enabled and pin input
// [RULE5] port c pullup enable, seven bits
// [RULE6] port d pullup enable, eight bits
// [RULE7] port d latch eight bits, reset keeps it
// [RULE8] port d direction: 1 drives; reset clears
// [RULE9] port d read: latch if output, pin otherwise
// [RULE10] port d 7/6 follow timer two selects
// [RULE11] timer one pins follow its selects
// [RULE12] spi off frees port d pins 3..1
// [RULE13] pin 0 slave select only spi slave
// [RULE14] spi pins: direction only selects read source
// [RULE15] port b bit 0 ignored for slave select
// [RULE16] port e latch six bits, reset keeps it
// [RULE17] serial off frees port e pins 1/0
// [RULE18] serial pins: direction only selects read source
// [RULE19] software writes latch before setting direction
// [RULE20] one bus access, pins sampled on clock
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_c_d_e
  import gpio_ports_pkg::*;
#(
  parameter int PORT_C_W = 7,
  parameter int PORT_D_W = 8,
  parameter int PORT_E_W = 6
) (
  // clock, reset, clock enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cen,
  // avalon-mm slave, byte address
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // port c pins
  input wire logic [PORT_C_W-1:0] pin_in_c,
  output logic [PORT_C_W-1:0] pin_out_c,
  output logic [PORT_C_W-1:0] pin_oe_n_c,
  output logic [PORT_C_W-1:0] pin_pullup_c,
  // port d pins
  input wire logic [PORT_D_W-1:0] pin_in_d,
  output logic [PORT_D_W-1:0] pin_out_d,
  output logic [PORT_D_W-1:0] pin_oe_n_d,
  output logic [PORT_D_W-1:0] pin_pullup_d,
  // port e pins
  input wire logic [PORT_E_W-1:0] pin_in_e,
  output logic [PORT_E_W-1:0] pin_out_e,
  output logic [PORT_E_W-1:0] pin_oe_n_e,
  // timer channels on port d pins 4..7
  input wire logic [TIM_CH_N-1:0] timer_out,
  input wire logic [TIM_CH_N-1:0] timer_drive,
  // spi clock, mosi, miso on port d pins 3..1
  input wire logic [SPI_PIN_N-1:0] spi_out,
  input wire logic [SPI_PIN_N-1:0] spi_drive,
  // serial transmit on port e pin 0
  input wire logic uart_tx,
  // sampled pin levels and sharing controls to peripherals
  output logic [PORT_D_W-1:0] level_d,
  output logic [PORT_E_W-1:0] level_e,
  output share_ctl_t share_ctl,
  output timer_sel_t timer_sel
);
  // data latches, not reset
  logic [PORT_C_W-1:0] port_c_latch_q;
  logic [PORT_D_W-1:0] port_d_latch_q;
  logic [PORT_E_W-1:0] port_e_latch_q;
  // direction and pullup enables
  logic [PORT_C_W-1:0] port_c_direction_q;
  logic [PORT_D_W-1:0] port_d_direction_q;
  logic [PORT_E_W-1:0] port_e_direction_q;
  logic [PORT_C_W-1:0] port_c_pullup_enable_q;
  logic [PORT_D_W-1:0] port_d_pullup_enable_q;
  // pin sharing controls
  share_ctl_t share_q;
  timer_sel_t timer_q;
  // bus slave state
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [5:0] idx;
  logic take;
  logic done;
  logic wr_en;
  logic [7:0] rd_mux;
  // per-port read values and samples
  logic [PORT_C_W-1:0] rd_c;
  logic [PORT_D_W-1:0] rd_d;
  logic [PORT_E_W-1:0] rd_e;
  logic [PORT_C_W-1:0] level_c;
  // ownership of port d and e pins
  logic [PORT_D_W-1:0] own_d;
  logic [PORT_D_W-1:0] own_out_d;
  logic [PORT_D_W-1:0] own_drv_d;
  logic [PORT_E_W-1:0] own_e;
  logic [PORT_E_W-1:0] own_out_e;
  logic [PORT_E_W-1:0] own_drv_e;

  // bus decode: first edge takes, second edge completes
  assign idx = address[ADDR_IDX_LSB +: 6];
  assign take = cen && (read || write) && waitrequest_q;
  assign done = cen && (read || write) && !waitrequest_q;
  assign wr_en = done && write && byteenable[LANE0];

  // waitrequest drops for one cycle per access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest_q <= 1'b1;
    end else if (take) begin
      waitrequest_q <= 1'b0; // [RULE20]
    end else if (done) begin
      waitrequest_q <= 1'b1;
    end
  end

  // read data captured at the taking edge, held until the next read access
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (take && read) begin
      readdata_q <= 32'(rd_mux); // [RULE20]
    end
  end

  // read multiplexer, unmapped words read zero
  always_comb begin
    case (idx)
      IDX_C_LATCH: rd_mux = 8'(rd_c); // [RULE2]
      IDX_D_LATCH: rd_mux = 8'(rd_d); // [RULE9] [RULE14]
      IDX_E_LATCH: rd_mux = 8'(rd_e); // [RULE18]
      IDX_C_DIR: rd_mux = 8'(port_c_direction_q);
      IDX_D_DIR: rd_mux = 8'(port_d_direction_q);
      IDX_E_DIR: rd_mux = 8'(port_e_direction_q);
      IDX_C_PUE: rd_mux = 8'(port_c_pullup_enable_q);
      IDX_D_PUE: rd_mux = 8'(port_d_pullup_enable_q);
      IDX_SHARE: rd_mux = share_q;
      IDX_TIMER: rd_mux = timer_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // data latches take every write with byte lane 0 enabled, whatever the direction
  always_ff @(posedge clock) begin
    if (wr_en && idx == IDX_C_LATCH) begin
      port_c_latch_q <= writedata[PORT_C_W-1:0]; // [RULE3]
    end
    if (wr_en && idx == IDX_D_LATCH) begin
      port_d_latch_q <= writedata[PORT_D_W-1:0]; // [RULE3] [RULE7]
    end
    if (wr_en && idx == IDX_E_LATCH) begin
      port_e_latch_q <= writedata[PORT_E_W-1:0]; // [RULE16]
    end
  end

  // direction registers clear on reset: all pins inputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port_c_direction_q <= PORT_C_W'(CTRL_RESET); // [RULE1]
      port_d_direction_q <= PORT_D_W'(CTRL_RESET); // [RULE8]
      port_e_direction_q <= PORT_E_W'(CTRL_RESET);
    end else if (wr_en) begin
      if (idx == IDX_C_DIR) begin
        port_c_direction_q <= writedata[PORT_C_W-1:0]; // [RULE1]
      end
      if (idx == IDX_D_DIR) begin
        port_d_direction_q <= writedata[PORT_D_W-1:0]; // [RULE8]
      end
      if (idx == IDX_E_DIR) begin
        port_e_direction_q <= writedata[PORT_E_W-1:0];
      end
    end
  end

  // pullup enables, one bit per pin
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port_c_pullup_enable_q <= PORT_C_W'(CTRL_RESET);
      port_d_pullup_enable_q <= PORT_D_W'(CTRL_RESET);
    end else if (wr_en) begin
      if (idx == IDX_C_PUE) begin
        port_c_pullup_enable_q <= writedata[PORT_C_W-1:0]; // [RULE5]
      end
      if (idx == IDX_D_PUE) begin
        port_d_pullup_enable_q <= writedata[PORT_D_W-1:0]; // [RULE6]
      end
    end
  end

  // sharing controls for spi, serial and timer channels
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      share_q <= CTRL_RESET;
      timer_q <= CTRL_RESET;
    end else if (wr_en) begin
      if (idx == IDX_SHARE) begin
        share_q <= writedata[7:0];
      end
      if (idx == IDX_TIMER) begin
        timer_q <= writedata[7:0];
      end
    end
  end

  // port d ownership: timers on 4..7, spi on 3..1, select on 0
  always_comb begin
    own_d = '0;
    own_out_d = '0;
    own_drv_d = '0;
    for (int i = 0; i < TIM_CH_N; i++) begin
      own_d[D_TIM_LO + i] = |timer_q[ELS_W*i +: ELS_W]; // [RULE10] [RULE11]
      own_out_d[D_TIM_LO + i] = timer_out[i];
      own_drv_d[D_TIM_LO + i] = timer_drive[i];
    end
    for (int i = 0; i < SPI_PIN_N; i++) begin
      own_d[D_SPI_LO + i] = share_q.serial_peripheral_enable; // [RULE12]
      own_out_d[D_SPI_LO + i] = spi_out[i];
      own_drv_d[D_SPI_LO + i] = spi_drive[i]; // [RULE14]
    end
    // slave select is an input; port b bit 0 never reaches it
    own_d[D_SS_PIN] = share_q.serial_peripheral_enable
      && !share_q.serial_peripheral_master_select; // [RULE13] [RULE15]
  end

  // port e ownership: transmit out on 0, receive in on 1
  always_comb begin
    own_e = '0;
    own_out_e = '0;
    own_drv_e = '0;
    own_e[E_TX_PIN] = share_q.async_serial_enable; // [RULE17]
    own_e[E_RX_PIN] = share_q.async_serial_enable; // [RULE17]
    own_out_e[E_TX_PIN] = uart_tx;
    own_drv_e[E_TX_PIN] = 1'b1; // [RULE18]
  end

  // port c: plain bidirectional pins with pullups
  gpio_pin_slice #(.W(PORT_C_W)) slice_c (
    .clock(clock),
    .sys_rst(sys_rst),
    .cen(cen),
    .latch(port_c_latch_q),
    .dir(port_c_direction_q),
    .pue(port_c_pullup_enable_q), // [RULE4]
    .own('0),
    .own_out('0),
    .own_drive('0),
    .pin_in(pin_in_c),
    .pin_out_q(pin_out_c),
    .pin_oe_n_q(pin_oe_n_c),
    .pullup_q(pin_pullup_c),
    .level_q(level_c),
    .rd_val(rd_c)
  );

  // port d: shared with timers and spi
  gpio_pin_slice #(.W(PORT_D_W)) slice_d (
    .clock(clock),
    .sys_rst(sys_rst),
    .cen(cen),
    .latch(port_d_latch_q),
    .dir(port_d_direction_q),
    .pue(port_d_pullup_enable_q), // [RULE4]
    .own(own_d),
    .own_out(own_out_d),
    .own_drive(own_drv_d),
    .pin_in(pin_in_d),
    .pin_out_q(pin_out_d),
    .pin_oe_n_q(pin_oe_n_d),
    .pullup_q(pin_pullup_d),
    .level_q(level_d),
    .rd_val(rd_d)
  );

  // port e: shared with the serial interface, no pullups
  gpio_pin_slice #(.W(PORT_E_W)) slice_e (
    .clock(clock),
    .sys_rst(sys_rst),
    .cen(cen),
    .latch(port_e_latch_q),
    .dir(port_e_direction_q),
    .pue('0),
    .own(own_e),
    .own_out(own_out_e),
    .own_drive(own_drv_e),
    .pin_in(pin_in_e),
    .pin_out_q(pin_out_e),
    .pin_oe_n_q(pin_oe_n_e),
    .pullup_q(),
    .level_q(level_e),
    .rd_val(rd_e)
  );

  // outputs straight from registers
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign share_ctl = share_q;
  assign timer_sel = timer_q;

  // checks
  default clocking chk_cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // bus handshake steps
  sequence bus_take_s;
    cen && (read || write) && waitrequest_q;
  endsequence
  sequence bus_ack_s;
    !waitrequest_q ##1 (waitrequest_q || !cen);
  endsequence

  bus_answer_a: assert property (bus_take_s |=> bus_ack_s) // [RULE20]
    else $error("bus access not answered in one cycle");
  c_dir_reset_a: assert property ($past(sys_rst) |-> port_c_direction_q == '0) // [RULE1]
    else $error("port c direction not cleared by reset");
  d_dir_reset_a: assert property ($past(sys_rst) |-> port_d_direction_q == '0 // [RULE8]
    && pin_oe_n_d == '1)
    else $error("port d not input after reset");
  c_read_mux_a: assert property (take && read && idx == IDX_C_LATCH |=> // [RULE2]
    readdata[PORT_C_W-1:0] == $past((port_c_direction_q & port_c_latch_q)
    | (~port_c_direction_q & level_c)))
    else $error("port c read source wrong");
  d_read_mux_a: assert property (take && read && idx == IDX_D_LATCH |=> // [RULE9]
    readdata[PORT_D_W-1:0] == $past((port_d_direction_q & port_d_latch_q)
    | (~port_d_direction_q & level_d)))
    else $error("port d read source wrong");
  c_latch_write_a: assert property (wr_en && idx == IDX_C_LATCH |=> // [RULE3]
    port_c_latch_q == $past(writedata[PORT_C_W-1:0]))
    else $error("port c latch write lost");
  e_latch_write_a: assert property (wr_en && idx == IDX_E_LATCH |=> // [RULE16]
    port_e_latch_q == $past(writedata[PORT_E_W-1:0]))
    else $error("port e latch write lost");
  d_pullup_write_a: assert property (wr_en && idx == IDX_D_PUE |=> // [RULE6]
    port_d_pullup_enable_q == $past(writedata[PORT_D_W-1:0]))
    else $error("port d pullup enable write lost");
  c_pullup_gate_a: assert property (cen |=> pin_pullup_c == // [RULE4]
    $past(port_c_pullup_enable_q & ~port_c_direction_q))
    else $error("port c pullup not gated by direction");
  spi_release_a: assert property (cen && !share_q.serial_peripheral_enable |=> // [RULE12]
    pin_oe_n_d[D_SPI_HI:D_SPI_LO] == ~$past(port_d_direction_q[D_SPI_HI:D_SPI_LO]))
    else $error("spi pins not returned to port use");
  slave_select_a: assert property (cen && share_q.serial_peripheral_enable // [RULE13]
    && !share_q.serial_peripheral_master_select |=> pin_oe_n_d[D_SS_PIN])
    else $error("slave select pin driven");
  timer_two_pin_a: assert property (cen && |timer_q.timer_two_channel_one |=> // [RULE10]
    pin_out_d[PORT_D_W-1] == $past(timer_out[TIM_CH_N-1]))
    else $error("timer two channel pin not routed");
  serial_pins_a: assert property (cen && share_q.async_serial_enable |=> // [RULE17]
    pin_out_e[E_TX_PIN] == $past(uart_tx) && !pin_oe_n_e[E_TX_PIN]
    && pin_oe_n_e[E_RX_PIN])
    else $error("serial pins not owned by serial interface");
endmodule : gpio_ports_c_d_e
`default_nettype wire

// >>> gpio_ports_c_d_e_tb.sv
// self-checking bench for the port c/d/e block
`timescale 1ns/100ps
`default_nettype none
module gpio_ports_c_d_e_tb
  import gpio_ports_pkg::*;
;
  // clock, reset and bus
  logic clock = 1'b0, sys_rst = 1'b1, cen = 1'b1, read = 1'b0, write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  // pins and outside drivers
  logic [6:0] pin_in_c, pin_out_c, pin_oe_n_c, pin_pullup_c, ext_c = 7'h2a, ext_en_c = 7'h7f;
  logic [7:0] pin_in_d, pin_out_d, pin_oe_n_d, pin_pullup_d, ext_d = 8'h3c, level_d;
  logic [7:0] ext_en_d = 8'hff;
  logic [5:0] pin_in_e, pin_out_e, pin_oe_n_e, ext_e = 6'h15, level_e;
  logic [5:0] ext_en_e = 6'h3f;
  // peripheral side
  logic [3:0] timer_out = 4'h0, timer_drive = 4'h0;
  logic [2:0] spi_out = 3'h3, spi_drive = 3'h5;
  logic uart_tx = 1'b0;
  logic [7:0] q, share_seen, timer_seen;
  int error_cnt = 0, cmp_count = 0;
  // 10 MHz clock
  always #50 clock = ~clock;
  gpio_ports_c_d_e dut (.clock(clock), .sys_rst(sys_rst), .cen(cen), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .pin_in_c(pin_in_c),
    .pin_out_c(pin_out_c), .pin_oe_n_c(pin_oe_n_c), .pin_pullup_c(pin_pullup_c),
    .pin_in_d(pin_in_d), .pin_out_d(pin_out_d), .pin_oe_n_d(pin_oe_n_d),
    .pin_pullup_d(pin_pullup_d), .pin_in_e(pin_in_e), .pin_out_e(pin_out_e),
    .pin_oe_n_e(pin_oe_n_e), .timer_out(timer_out), .timer_drive(timer_drive),
    .spi_out(spi_out), .spi_drive(spi_drive), .uart_tx(uart_tx), .level_d(level_d),
    .level_e(level_e), .share_ctl(share_seen), .timer_sel(timer_seen));
  // outside world of each port
  gpio_pin_world #(.W(7)) world_c (.clock(clock), .pin_out(pin_out_c), .oe_n(pin_oe_n_c),
    .pull_on(pin_pullup_c), .ext(ext_c), .ext_en(ext_en_c), .level(pin_in_c));
  gpio_pin_world #(.W(8)) world_d (.clock(clock), .pin_out(pin_out_d), .oe_n(pin_oe_n_d),
    .pull_on(pin_pullup_d), .ext(ext_d), .ext_en(ext_en_d), .level(pin_in_d));
  gpio_pin_world #(.W(6)) world_e (.clock(clock), .pin_out(pin_out_e), .oe_n(pin_oe_n_e),
    .pull_on(6'h00), .ext(ext_e), .ext_en(ext_en_e), .level(pin_in_e));
  // verdict and end of run
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    @(posedge clock);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    n = 0;
    // waitrequest is read at the edge itself, before the slave updates it
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      $display("mismatch at %0t: bus hang", $time);
      conclude();
    end
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  // register write
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d, q);
  endtask : wr
  // register read and compare
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask : rd
  // let a register change reach the pins
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  // reset pulse of eight cycles
  task automatic rst();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : rst
  // main sequence
  initial begin
    logic [5:0] ctl [7];
    ctl = '{IDX_C_DIR, IDX_D_DIR, IDX_E_DIR, IDX_C_PUE, IDX_D_PUE, IDX_SHARE, IDX_TIMER};
    rst();
    // control registers come up cleared, pins as inputs
    for (int i = 0; i < 7; i++) rd(ctl[i], 8'h00);
    chk({1'b0, pin_oe_n_c}, 8'h7f);
    // latch written while input: pins still read
    wr(IDX_C_LATCH, 8'h55);
    rd(IDX_C_LATCH, 8'h2a);
    chk({1'b0, pin_oe_n_c}, 8'h7f);
    wr(IDX_C_DIR, 8'h0f);
    settle();
    rd(IDX_C_LATCH, 8'h25);
    chk({1'b0, pin_oe_n_c}, 8'h70);
    chk({1'b0, pin_out_c} & 8'h0f, 8'h05);
    // pullups on inputs only, outside driver released
    wr(IDX_C_PUE, 8'h7f);
    ext_en_c <= 7'h00;
    settle();
    rd(IDX_C_PUE, 8'h7f);
    chk({1'b0, pin_pullup_c}, 8'h70);
    rd(IDX_C_LATCH, 8'h75);
    // port d latch, direction, pullup
    wr(IDX_D_LATCH, 8'ha5);
    wr(IDX_D_DIR, 8'hff);
    wr(IDX_D_PUE, 8'hff);
    settle();
    rd(IDX_D_LATCH, 8'ha5);
    chk(pin_out_d, 8'ha5);
    chk(pin_oe_n_d, 8'h00);
    chk(pin_pullup_d, 8'h00);
    rd(IDX_D_PUE, 8'hff);
    // refused writes: lane disabled, unmapped index
    byteenable <= 4'h0;
    wr(IDX_D_LATCH, 8'h00);
    byteenable <= 4'hf;
    rd(IDX_D_LATCH, 8'ha5);
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h00);
    wr(IDX_D_DIR, 8'hf0);
    settle();
    chk(pin_pullup_d, 8'h0f);
    rd(IDX_D_LATCH, 8'hac);
    chk(level_d, 8'hac);
    // clock enable low freezes the pin samples
    cen <= 1'b0;
    ext_d <= 8'h03;
    settle();
    chk(level_d, 8'hac);
    cen <= 1'b1;
    settle();
    chk(level_d, 8'ha3);
    // outside driver released: pullups hold input pins high
    ext_en_d <= 8'h00;
    settle();
    rd(IDX_D_LATCH, 8'haf);
    // port e six bits
    wr(IDX_E_LATCH, 8'hff);
    wr(IDX_E_DIR, 8'h3f);
    rd(IDX_E_LATCH, 8'h3f);
    wr(IDX_E_DIR, 8'h00);
    settle();
    rd(IDX_E_LATCH, 8'h15);
    chk({2'h0, level_e}, 8'h15);
    // second reset clears directions, keeps latches
    rst();
    settle();
    chk(pin_oe_n_d, 8'hff);
    chk({1'b0, pin_oe_n_c}, 8'h7f);
    wr(IDX_D_DIR, 8'hff);
    wr(IDX_E_DIR, 8'h3f);
    rd(IDX_D_LATCH, 8'ha5);
    rd(IDX_E_LATCH, 8'h3f);
    // spi slave takes pins 3..0
    wr(IDX_SHARE, 8'h01);
    settle();
    chk({4'h0, pin_oe_n_d[3:0]}, 8'h05);
    chk({6'h00, pin_out_d[3], pin_out_d[1]}, 8'h01);
    chk(share_seen, 8'h01);
    rd(IDX_D_LATCH, 8'ha5);
    wr(IDX_SHARE, 8'h03);
    settle();
    chk({7'h00, pin_oe_n_d[0]}, 8'h00);
    wr(IDX_SHARE, 8'h00);
    settle();
    chk({4'h0, pin_oe_n_d[3:0]}, 8'h00);
    chk({4'h0, pin_out_d[3:0]}, 8'h05);
    // each timer channel with one nonzero select code, codes 1, 2, 3, 1 in turn
    for (int i = 0; i < 4; i++) begin
      wr(IDX_TIMER, 8'((i % 3) + 1) << (2 * i));
      settle();
      chk({4'h0, pin_oe_n_d[7:4]}, 8'(1 << i));
    end
    timer_drive <= 4'hf;
    timer_out <= 4'h6;
    wr(IDX_TIMER, 8'hff);
    settle();
    chk({4'h0, pin_out_d[7:4]}, 8'h06);
    chk(timer_seen, 8'hff);
    // serial interface owns port e pins 1/0
    wr(IDX_E_LATCH, 8'h00);
    uart_tx <= 1'b1;
    wr(IDX_SHARE, 8'h04);
    settle();
    chk({7'h00, pin_out_e[0]}, 8'h01);
    chk({7'h00, pin_oe_n_e[1]}, 8'h01);
    rd(IDX_E_LATCH, 8'h00);
    wr(IDX_SHARE, 8'h00);
    settle();
    chk({2'h0, pin_oe_n_e}, 8'h00);
    chk({7'h00, pin_out_e[0]}, 8'h00);
    conclude();
  end
endmodule : gpio_ports_c_d_e_tb
`default_nettype wire

// >>> gpio_ports_pkg.sv
// shared constants and carriers for the port c/d/e block
package gpio_ports_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_C_LATCH = 6'h02;
  localparam logic [5:0] IDX_D_LATCH = 6'h03;
  localparam logic [5:0] IDX_E_LATCH = 6'h08;
  localparam logic [5:0] IDX_C_DIR = 6'h10;
  localparam logic [5:0] IDX_D_DIR = 6'h11;
  localparam logic [5:0] IDX_E_DIR = 6'h12;
  localparam logic [5:0] IDX_C_PUE = 6'h13;
  localparam logic [5:0] IDX_D_PUE = 6'h14;
  localparam logic [5:0] IDX_SHARE = 6'h15;
  localparam logic [5:0] IDX_TIMER = 6'h16;
  // lowest address bit of the word index
  localparam int ADDR_IDX_LSB = 2;
  // byte lane that carries register data
  localparam int LANE0 = 0;
  // reset value of direction, pullup and sharing registers
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // width of one timer channel edge/level select field
  localparam int ELS_W = 2;
  // port d pin positions
  localparam int D_SS_PIN = 0;
  localparam int D_SPI_LO = 1;
  localparam int D_SPI_HI = 3;
  localparam int D_TIM_LO = 4;
  localparam int TIM_CH_N = 4;
  localparam int SPI_PIN_N = 3;
  // port e pin positions
  localparam int E_TX_PIN = 0;
  localparam int E_RX_PIN = 1;
  // sharing control bits, bit 7 downward
  typedef struct packed {
    logic [4:0] unused;
    logic async_serial_enable;
    logic serial_peripheral_master_select;
    logic serial_peripheral_enable;
  } share_ctl_t;
  // edge/level select fields, one per timer channel on port d
  typedef struct packed {
    logic [1:0] timer_two_channel_one;
    logic [1:0] timer_two_channel_zero;
    logic [1:0] timer_one_channel_one;
    logic [1:0] timer_one_channel_zero;
  } timer_sel_t;
endpackage : gpio_ports_pkg
